/* File: verilog/jmr_pkg.sv */
// Package for the jump, move and return execution block.
// Holds instruction encodings, field positions, widths and reset values.
// Assumes nothing of its surroundings; imported by scope only.
`default_nettype none
package jmr_pkg;
  // Widths
  localparam int unsigned INSTR_W   = 14;  // Instruction word width
  localparam int unsigned PC_W      = 11;  // Program counter width
  localparam int unsigned DATA_W    = 8;   // Data path width
  localparam int unsigned ADDR_W    = 7;   // Data location address width
  localparam int unsigned STACK_D   = 8;   // Default stack depth
  // Field positions
  localparam int unsigned DEST_BIT  = 7;   // Destination select bit
  localparam int unsigned OP_HI     = 13;  // Top bit of opcode fields
  localparam int unsigned OP3_LO    = 11;  // Low bit of 3-bit jump opcode
  localparam int unsigned OP6_LO    = 8;   // Low bit of 6-bit literal opcode
  localparam int unsigned OP7_LO    = 7;   // Low bit of 7-bit store opcode
  // Opcode values
  localparam logic [2:0] OP_LONG_JUMP   = 3'h5;   // Long jump, 11-bit target
  localparam logic [2:0] OP_CALL        = 3'h4;   // Subroutine call
  localparam logic [5:0] OP_LOAD_LIT    = 6'h30;  // Load literal into working
  localparam logic [5:0] OP_RET_LIT     = 6'h31;  // Return with literal
  localparam logic [5:0] OP_MOVE_LOC    = 6'h08;  // Move location, d in bit 7
  localparam logic [6:0] OP_STORE_WORK  = 7'h01;  // Store working to location
  localparam logic [13:0] INSTR_NOP     = 14'h0000; // No operation
  // Reset values
  localparam logic [10:0] PC_RST   = 11'h000;  // Program counter at reset
  localparam logic [7:0]  WORK_RST = 8'h00;    // Working register at reset
  localparam logic        ZERO_RST = 1'b0;     // Zero flag at reset
  // Decoded operation classes
  typedef enum logic [2:0] {
    JMR_OP_NOP   = 3'b000,
    JMR_OP_JUMP  = 3'b001,
    JMR_OP_CALL  = 3'b010,
    JMR_OP_LIT   = 3'b011,
    JMR_OP_RET   = 3'b100,
    JMR_OP_STORE = 3'b101,
    JMR_OP_MOVE  = 3'b110
  } jmr_op_t;
endpackage
`default_nettype wire

/* File: verilog/jmr_mem_if.sv */
// Interface between the execution core and its data memory.
// Assumes both ends share the core clock.
`default_nettype none
interface jmr_mem_if;
  logic [6:0] rd_addr;  // Read address, data returns next cycle
  logic [7:0] rd_data;  // Registered read data
  logic       wr_en;    // Write strobe
  logic [6:0] wr_addr;  // Write address
  logic [7:0] wr_data;  // Write data
  modport ctrl (output rd_addr, output wr_en, output wr_addr, output wr_data,
                input rd_data);
  modport mem  (input rd_addr, input wr_en, input wr_addr, input wr_data,
                output rd_data);
endinterface
`default_nettype wire

/* File: verilog/jmr_dmem.sv */
// Data memory of 128 locations with registered read data.
// Assumes core clock; a read and write to the same address return old data.
`default_nettype none
module jmr_dmem #(
  parameter int unsigned DEPTH = 128  // Number of locations
) (
  input  wire logic i_core_clk,  // Core clock
  jmr_mem_if.mem    mem          // Port to the core
);
  logic [7:0] store_r [DEPTH];  // Location array

  // Write port
  always_ff @(posedge i_core_clk) begin
    if (mem.wr_en) begin
      store_r[mem.wr_addr] <= mem.wr_data;
    end
  end

  // Registered read port
  always_ff @(posedge i_core_clk) begin
    mem.rd_data <= store_r[mem.rd_addr];
  end
endmodule
`default_nettype wire

/* File: verilog/jmr_core.sv */
// Execution core for long jump, call, literal load, store, move, nop, return.
// Assumes program memory returns i_instr for o_pc in the same cycle.
//
// Contract
// [RL1] Long jump loads 11-bit target into counter
// [RL2] Long jump: two cycles, flags untouched
// [RL3] Load literal writes working register, one cycle
// [RL4] Store copies working register to location
// [RL5] Move sends location to working or back
// [RL6] Move updates zero flag from moved value
// [RL7] No-operation only advances program counter
// [RL8] Return loads literal and pops counter together
// [RL9] Return: two cycles, pointer down, flags untouched
// [RL10] Call pushes address after the call
// [RL11] Transfers discard prefetch, execute no-operation
`default_nettype none
module jmr_core #(
  parameter int unsigned STACK_DEPTH = jmr_pkg::STACK_D  // Stack entries
) (
  input  wire logic        i_core_clk,  // Core clock, 25 MHz
  input  wire logic        i_rst_n,     // Asynchronous reset, active low
  input  wire logic [13:0] i_instr,     // Fetched instruction at o_pc
  output var  logic [10:0] o_pc,        // Fetch address
  output var  logic [7:0]  o_working,   // Working register
  output var  logic        o_zero,      // Zero flag
  output var  logic [2:0]  o_sp         // Stack pointer
);
  localparam int unsigned SP_W = $clog2(STACK_DEPTH);  // Pointer width

  jmr_mem_if mem_bus ();  // Data memory link

  logic [13:0]      instr_r;               // Instruction being executed
  logic [10:0]      pc_r;                  // Program counter
  logic [7:0]       work_r;                // Working register
  logic             zero_r;                // Zero flag
  logic [SP_W-1:0]  sp_r;                  // Stack pointer
  logic [10:0]      stack_r [STACK_DEPTH]; // Return address stack
  logic             fwd_hit_r;             // Last write hit the read address
  logic [7:0]       fwd_data_r;            // Data of that write
  jmr_pkg::jmr_op_t op;                    // Decoded class
  logic [7:0]       loc_val;               // Location value seen now
  logic [SP_W-1:0]  sp_dec;                // Pointer after pop

  // Decode an instruction word into its class
  function automatic jmr_pkg::jmr_op_t decode(input logic [13:0] w);
    if (w[jmr_pkg::OP_HI:jmr_pkg::OP3_LO] == jmr_pkg::OP_LONG_JUMP) begin
      return jmr_pkg::JMR_OP_JUMP;
    end else if (w[jmr_pkg::OP_HI:jmr_pkg::OP3_LO] == jmr_pkg::OP_CALL) begin
      return jmr_pkg::JMR_OP_CALL;
    end else if (w[jmr_pkg::OP_HI:jmr_pkg::OP6_LO] == jmr_pkg::OP_LOAD_LIT) begin
      return jmr_pkg::JMR_OP_LIT;
    end else if (w[jmr_pkg::OP_HI:jmr_pkg::OP6_LO] == jmr_pkg::OP_RET_LIT) begin
      return jmr_pkg::JMR_OP_RET;
    end else if (w[jmr_pkg::OP_HI:jmr_pkg::OP6_LO] == jmr_pkg::OP_MOVE_LOC) begin
      return jmr_pkg::JMR_OP_MOVE;
    end else if (w[jmr_pkg::OP_HI:jmr_pkg::OP7_LO] == jmr_pkg::OP_STORE_WORK) begin
      return jmr_pkg::JMR_OP_STORE;
    end
    // Unknown codes behave as no-operation
    return jmr_pkg::JMR_OP_NOP;
  endfunction

  jmr_dmem #(
    .DEPTH (128)
  ) u_dmem (
    .i_core_clk (i_core_clk),
    .mem        (mem_bus.mem)
  );

  assign op     = decode(instr_r);
  assign sp_dec = sp_r - SP_W'(1);

  // Read address comes from the prefetched word so data is ready at execute
  assign mem_bus.rd_addr = i_instr[6:0];
  assign loc_val = fwd_hit_r ? fwd_data_r : mem_bus.rd_data;

  // Data memory writes: store and move back to location
  always_comb begin
    mem_bus.wr_addr = instr_r[6:0];
    mem_bus.wr_en   = 1'b0;
    mem_bus.wr_data = work_r;
    if (op == jmr_pkg::JMR_OP_STORE) begin
      mem_bus.wr_en = 1'b1;  // RL4
    end else if (op == jmr_pkg::JMR_OP_MOVE && instr_r[jmr_pkg::DEST_BIT]) begin
      mem_bus.wr_en   = 1'b1;  // RL5
      mem_bus.wr_data = loc_val;
    end
  end

  // Forward a write that lands on the address now being read
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fwd_hit_r  <= 1'b0;
      fwd_data_r <= 8'h00;
    end else begin
      fwd_hit_r  <= mem_bus.wr_en && (mem_bus.wr_addr == mem_bus.rd_addr);
      fwd_data_r <= mem_bus.wr_data;
    end
  end

  // Program counter and instruction register
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pc_r    <= jmr_pkg::PC_RST;
      instr_r <= jmr_pkg::INSTR_NOP;
    end else begin
      unique case (op)
        jmr_pkg::JMR_OP_JUMP, jmr_pkg::JMR_OP_CALL: begin
          pc_r    <= instr_r[10:0];  // RL1
          instr_r <= jmr_pkg::INSTR_NOP;  // RL11
        end
        jmr_pkg::JMR_OP_RET: begin
          pc_r    <= stack_r[sp_dec];  // RL8
          instr_r <= jmr_pkg::INSTR_NOP;  // RL9
        end
        default: begin
          pc_r    <= pc_r + 11'h001;  // RL7
          instr_r <= i_instr;
        end
      endcase
    end
  end

  // Return stack and its pointer
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sp_r <= '0;
    end else if (op == jmr_pkg::JMR_OP_CALL) begin
      sp_r <= sp_r + SP_W'(1);
    end else if (op == jmr_pkg::JMR_OP_RET) begin
      sp_r <= sp_dec;  // RL9
    end
  end

  // Push: pc_r already points past the call
  always_ff @(posedge i_core_clk) begin
    if (op == jmr_pkg::JMR_OP_CALL) begin
      stack_r[sp_r] <= pc_r;  // RL10
    end
  end

  // Working register
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      work_r <= jmr_pkg::WORK_RST;
    end else if (op == jmr_pkg::JMR_OP_LIT || op == jmr_pkg::JMR_OP_RET) begin
      work_r <= instr_r[7:0];  // RL3 RL8
    end else if (op == jmr_pkg::JMR_OP_MOVE && !instr_r[jmr_pkg::DEST_BIT]) begin
      work_r <= loc_val;  // RL5
    end
  end

  // Zero flag, only move touches it
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      zero_r <= jmr_pkg::ZERO_RST;
    end else if (op == jmr_pkg::JMR_OP_MOVE) begin
      zero_r <= (loc_val == 8'h00);  // RL6
    end
    // Jump and return leave it alone: RL2
  end

  // Outputs straight from registers
  assign o_pc      = pc_r;
  assign o_working = work_r;
  assign o_zero    = zero_r;
  assign o_sp      = 3'(sp_r);
endmodule
`default_nettype wire

/* File: verif/jmr_core_sva.sv */
// Checker for jmr_core: shadows the execute slot and ties outputs to it.
// Assumes it is bound into jmr_core and sees only its ports.
`default_nettype none
module jmr_core_sva (
  input wire logic        i_core_clk,  // Core clock
  input wire logic        i_rst_n,     // Reset, active low
  input wire logic [13:0] i_instr,     // Fetched word
  input wire logic [10:0] o_pc,        // Fetch address
  input wire logic [7:0]  o_working,   // Working register
  input wire logic        o_zero,      // Zero flag
  input wire logic [2:0]  o_sp         // Stack pointer
);
  logic [13:0] ex_r;                        // Word now executing
  wire logic   jmp = ex_r[13:11] == 3'h5;   // Long jump
  wire logic   cal = ex_r[13:11] == 3'h4;   // Call
  wire logic   ret = ex_r[13:8] == 6'h31;   // Return with literal
  wire logic   lit = ex_r[13:8] == 6'h30;   // Load literal
  wire logic   mov = ex_r[13:8] == 6'h08;   // Move location
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // Mirror of the slot; a transfer drops the prefetched word
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ex_r <= 14'h0000;
    end else begin
      ex_r <= (jmp || cal || ret) ? 14'h0000 : i_instr;
    end
  end
  AST_JUMP: assert property (jmp |=> o_pc == $past(ex_r[10:0]) && $stable(o_zero))
    else $error("jump target wrong");
  AST_FLUSH: assert property ((jmp || cal || ret) |=> ##1 o_pc == $past(o_pc) + 11'h001)
    else $error("prefetch not flushed");
  AST_LIT: assert property (lit |=> o_working == $past(ex_r[7:0]) && $stable(o_zero))
    else $error("literal load wrong");
  AST_STORE: assert property (ex_r[13:7] == 7'h01 |=> $stable(o_working) && $stable(o_zero))
    else $error("store changed state");
  AST_MOVE: assert property (mov && !ex_r[7] |=> o_zero == (o_working == 8'h00))
    else $error("move zero flag wrong");
  AST_NOP: assert property (ex_r == 14'h0000 |=> o_pc == $past(o_pc) + 11'h001 && $stable(o_working))
    else $error("nop changed state");
  AST_RET: assert property (ret |=> o_working == $past(ex_r[7:0]) && o_sp == $past(o_sp) - 3'h1)
    else $error("return wrong");
  AST_CALL: assert property (cal |=> o_sp == $past(o_sp) + 3'h1 && o_pc == $past(ex_r[10:0]))
    else $error("call wrong");
  // Main scenarios reached
  cover property (jmp);
  cover property (ret);
  cover property (mov && ex_r[7]);
endmodule
bind jmr_core jmr_core_sva jmr_core_sva_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
  .i_instr(i_instr), .o_pc(o_pc), .o_working(o_working), .o_zero(o_zero), .o_sp(o_sp));
`default_nettype wire

/* File: verif/jmr_core_tb_top.sv */
// Testbench for jmr_core: runs small programs from a behavioural memory.
// Assumes the core reads i_instr for o_pc; inputs change at falling edges.
`default_nettype none
module jmr_core_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;       // Core clock, 40 ns
  logic        rst_n = 1'b0;     // Reset, active low
  logic [13:0] instr = 14'h0000; // Word at fetch address
  logic [10:0] pc;               // Fetch address
  logic [7:0]  working;          // Working register
  logic        zero;             // Zero flag
  logic [2:0]  sp;               // Stack pointer
  logic [13:0] prog [0:2047];    // Program memory
  int          err_count = 0;    // Mismatches
  int          comparisons = 0;  // Checks made
  always #20 clk = ~clk;
  // Program memory answers at falling edges
  always @(negedge clk) instr = prog[pc];
  jmr_core jmr_core_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_instr(instr), .o_pc(pc),
    .o_working(working), .o_zero(zero), .o_sp(sp));
  task automatic chk(string name, logic [10:0] exp, logic [10:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic step(int n);
    repeat (n) @(negedge clk);
  endtask
  // Reset ten cycles, then run n edges; memory is cleared by clr
  task automatic go(int n);
    rst_n = 1'b0;
    step(10);
    rst_n = 1'b1;
    step(n);
  endtask
  task automatic clr();
    foreach (prog[i]) prog[i] = 14'h0000;
  endtask
  task automatic t_jump();
    clr();
    prog[0] = 14'h30A5;
    prog[1] = 14'h2FFF;
    prog[2] = 14'h3011;
    go(3);
    chk("pc", 11'h7FF, pc);
    chk("working", 11'h0A5, {3'h0, working});
    step(1);
    chk("pc", 11'h000, pc);
    chk("working", 11'h0A5, {3'h0, working});
    chk("zero", 11'h000, {10'h000, zero});
  endtask
  task automatic t_call_ret();
    clr();
    prog[0] = 14'h2100;
    prog[257] = 14'h313C;
    go(2);
    chk("pc", 11'h100, pc);
    chk("sp", 11'h001, {8'h00, sp});
    step(3);
    chk("pc", 11'h001, pc);
    chk("working", 11'h03C, {3'h0, working});
    chk("sp", 11'h000, {8'h00, sp});
    step(1);
    chk("pc", 11'h002, pc);
  endtask
  task automatic t_store_move();
    clr();
    prog[0]  = 14'h3000;
    prog[1]  = 14'h0080;
    prog[2]  = 14'h3077;
    prog[3]  = 14'h0880;
    prog[4]  = 14'h305A;
    prog[5]  = 14'h00FF;
    prog[6]  = 14'h3000;
    prog[7]  = 14'h087F;
    // Store then move of an unwritten location back to back: needs forwarding
    prog[8]  = 14'h30C3;
    prog[9]  = 14'h0085;
    prog[10] = 14'h0805;
    go(5);
    chk("zero", 11'h001, {10'h000, zero});
    chk("working", 11'h077, {3'h0, working});
    chk("pc", 11'h005, pc);
    step(4);
    chk("working", 11'h05A, {3'h0, working});
    chk("zero", 11'h000, {10'h000, zero});
    step(3);
    chk("working", 11'h0C3, {3'h0, working});
    chk("zero", 11'h000, {10'h000, zero});
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    clr();
    t_jump();
    t_call_ret();
    t_store_move();
    tally_and_finish();
  end
endmodule
`default_nettype wire
